// ===== pkg/sscc_map.vh
// Constants of the spread spectrum clock control block
// Assumes one reference clock of 20 MHz drives all logic
`ifndef SSCC_MAP_VH
`define SSCC_MAP_VH

// Reference clock and timing
`define SSCC_CLK_MHZ        20
`define SSCC_LOCK_TIME_US   5000
`define SSCC_OFF_MAX_CYC    4
`define SSCC_EN_MAX_CYC     4

// Select codes
`define SSCC_SEL_X2_C25     3'h0
`define SSCC_SEL_X2_C15     3'h1
`define SSCC_SEL_X2_C25B    3'h2
`define SSCC_SEL_X1_C25     3'h3
`define SSCC_SEL_D2_LO      3'h4
`define SSCC_SEL_RSV_A      3'h5
`define SSCC_SEL_D2_HI      3'h6
`define SSCC_SEL_RSV_B      3'h7

// Ratios P/Q, unsigned with 12 fraction bits
`define SSCC_RATIO_X1       16'h1000
`define SSCC_RATIO_X2       16'h2000
`define SSCC_RATIO_D2_LO    16'h4A7E
`define SSCC_RATIO_D2_HI    16'h6FBF

// Spread fractions with 16 fraction bits: 2.5, 1.5 and 2 percent
`define SSCC_SPREAD_2P5     16'h0666
`define SSCC_SPREAD_1P5     16'h03D7
`define SSCC_SPREAD_2P0     16'h051F

// Waveform table and output oscillator
`define SSCC_WAVE_FULL      10'h100
`define SSCC_MOD_STEP_CYC   2
`define SSCC_NCO_WIDTH      16

`endif

// ===== rtl/sscc_profile_gen.v
// Modulation profile generator: phase counter and fixed triangle table
// Assumes restart is a one-cycle pulse on sys_clk
`timescale 1ns/1ns
`include "sscc_map.vh"

module sscc_profile_gen
#(
    parameter STEP_CYCLES = `SSCC_MOD_STEP_CYC
)
(
    // Clock and reset
    input  wire              sys_clk,
    input  wire              reset,
    // Control
    input  wire              restart,
    input  wire              hold,
    // Profile
    output reg  [7:0]        phase_ff,
    output reg  signed [9:0] wave_ff
);

    reg  [7:0]        step_cnt_ff;
    reg  [7:0]        nxt_phase;
    reg  [7:0]        nxt_step_cnt;

    // Triangle from the phase index, start at center rising
    function signed [9:0] tri_wave;
        input [7:0] idx;
        begin
            if (idx < 8'h40)
                tri_wave = $signed({2'h0, idx}) <<< 2;
            else if (idx < 8'hC0)
                tri_wave = ($signed(10'h080) - $signed({2'h0, idx})) <<< 2;
            else
                tri_wave = ($signed({2'h0, idx}) - $signed(10'h100)) <<< 2;
        end
    endfunction

    always @*
    begin
        nxt_phase    = phase_ff;
        nxt_step_cnt = step_cnt_ff;
        if (restart || hold)
        begin
            nxt_phase    = 8'h00;                               // [R7] [R18]
            nxt_step_cnt = 8'h00;
        end
        else if (step_cnt_ff == STEP_CYCLES - 1)
        begin
            nxt_phase    = phase_ff + 8'h01;                    // [R2] [R18]
            nxt_step_cnt = 8'h00;
        end
        else
        begin
            nxt_step_cnt = step_cnt_ff + 8'h01;
        end
    end

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            phase_ff    <= 8'h00;                               // [R18]
            step_cnt_ff <= 8'h00;
            wave_ff     <= 10'h000;
        end
        else
        begin
            phase_ff    <= nxt_phase;
            step_cnt_ff <= nxt_step_cnt;
            wave_ff     <= tri_wave(nxt_phase);                 // [R3]
        end
    end

endmodule // sscc_profile_gen

// ===== rtl/sscc_clock_control.v
// Spread spectrum clock control: select decode, modulation, power-down
// Assumes sys_clk is the reference clock; all pins are asynchronous
//
// Operation
// R1 - Average output frequency equals reference times feedback over reference divider.
// R2 - Sweep frequency slowly; modulation rate near one thousandth of output.
// R3 - Waveform shape and rate fixed; only spread percentage follows select.
// R4 - Code 000 gives twice reference with symmetric 2.5 percent spread.
// R5 - Center-spread band is symmetric about the programmed average.
// R6 - Down-spread sweeps up to the maximum and never exceeds it.
// R7 - Reset returns the modulation profile to its starting point.
// R8 - Reference output pin carries a buffered copy of the reference.
// R9 - Spread-off high stops modulation; undriven pin keeps spreading on.
// R10 - Power-down low disables clock outputs; undriven means normal operation.
// R11 - Outputs stop within 4 reference cycles after power-down asserted.
// R12 - Outputs enable or disable within 4 reference cycles of control.
// R13 - First locked output cycle within 5 ms after power-down released.
// R14 - Other party restarts profile by a low-to-high reset pin edge.
// R15 - Reference output runs only while reference-enable low is held low.
// R16 - Codes 001 center 1.5 percent; 101, 111 reserved; 100, 110 down-spread.
// R17 - Reference output high-impedance when power-down and enable both high.
// R18 - Free-running phase counter over fixed table; reset clears, spread-off freezes (the code clears the phase to 0 and holds it there).
`timescale 1ns/1ns
`include "sscc_map.vh"

module sscc_clock_control
#(
    parameter LOCK_CYCLES = `SSCC_LOCK_TIME_US * `SSCC_CLK_MHZ,
    parameter LOCK_W      = 17,
    parameter NCO_W       = `SSCC_NCO_WIDTH,
    parameter STEP_CYCLES = `SSCC_MOD_STEP_CYC
)
(
    // Clock and reset
    input  wire        sys_clk,
    input  wire        reset,
    // Control pins
    input  wire [2:0]  spread_select,
    input  wire        spread_off_n_input,
    input  wire        power_down_n,
    input  wire        reference_output_enable_n,
    input  wire        profile_reset_pin,
    // Clock outputs
    output reg         modulated_clock_out,
    output reg         buffered_reference_out,
    output reg         buffered_reference_oe,
    // Status
    output reg  [15:0] freq_word_out,
    output reg         pll_locked,
    output reg         select_reserved
);

    // Pin synchronisers
    reg  [2:0]  sel_meta_ff;
    reg  [2:0]  sel_sync_ff;
    reg  [2:0]  sel_prev_ff;
    reg  [2:0]  sel_hold_ff;
    reg  [2:0]  nxt_sel_hold;
    reg         soff_meta_ff;
    reg         soff_sync_ff;
    reg         pdn_meta_ff;
    reg         pdn_sync_ff;
    reg         reference_output_enable_n_meta_ff;
    reg         reference_output_enable_n_sync_ff;
    reg         prst_meta_ff;
    reg         prst_sync_ff;
    reg         prst_prev_ff;

    // Lock timer
    reg  [LOCK_W-1:0] lock_cnt_ff;
    reg  [LOCK_W-1:0] nxt_lock_cnt;
    reg               locked_ff;
    reg               nxt_locked;

    // Frequency path
    reg  [NCO_W-1:0]  nco_acc_ff;
    reg  [NCO_W-1:0]  nxt_nco_acc;
    reg  [15:0]       freq_word_ff;
    reg  [15:0]       nxt_freq_word;
    reg  [15:0]       ratio;
    reg  [15:0]       spread;
    reg               down_mode;
    reg               reserved;

    wire              restart;
    wire              spread_off;
    wire              clk_run;
    wire signed [9:0] wave;

    reg  [31:0]        dev_prod;
    reg  signed [16:0] dev_full;
    reg  signed [10:0] wave_eff;
    reg  signed [27:0] dev_scaled;
    reg  signed [18:0] dev_shift;
    reg  signed [18:0] freq_sum;

    // Select decode: ratio, spread and mode
    function [33:0] sel_decode;
        input [2:0] sel;
        begin
            if (sel == `SSCC_SEL_X2_C25)
                sel_decode = {`SSCC_RATIO_X2, `SSCC_SPREAD_2P5, 2'b00};       // [R4]
            else if (sel == `SSCC_SEL_X2_C15)
                sel_decode = {`SSCC_RATIO_X2, `SSCC_SPREAD_1P5, 2'b00};       // [R16]
            else if (sel == `SSCC_SEL_X2_C25B)
                sel_decode = {`SSCC_RATIO_X2, `SSCC_SPREAD_2P5, 2'b00};
            else if (sel == `SSCC_SEL_X1_C25)
                sel_decode = {`SSCC_RATIO_X1, `SSCC_SPREAD_2P5, 2'b00};
            else if (sel == `SSCC_SEL_D2_LO)
                sel_decode = {`SSCC_RATIO_D2_LO, `SSCC_SPREAD_2P0, 2'b10};    // [R16]
            else if (sel == `SSCC_SEL_D2_HI)
                sel_decode = {`SSCC_RATIO_D2_HI, `SSCC_SPREAD_2P0, 2'b10};    // [R16]
            else
                sel_decode = {16'h0000, 16'h0000, 2'b01};                     // [R16]
        end
    endfunction

    // Synchronise the select pins through two flops
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            sel_meta_ff <= 3'h7;
            sel_sync_ff <= 3'h7;
        end
        else
        begin
            sel_meta_ff <= spread_select;
            sel_sync_ff <= sel_meta_ff;
        end
    end

    // Take a select code only once it reads the same twice
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            sel_prev_ff <= 3'h7;
            sel_hold_ff <= 3'h7;
        end
        else
        begin
            sel_prev_ff <= sel_sync_ff;
            sel_hold_ff <= nxt_sel_hold;
        end
    end

    // An intermediate select code that lasts a single cycle is never decoded
    always @*
    begin
        if (sel_sync_ff == sel_prev_ff)
            nxt_sel_hold = sel_sync_ff;                            // [R16]
        else
            nxt_sel_hold = sel_hold_ff;
    end

    // Synchronise spread-off and power-down
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            soff_meta_ff <= 1'b0;
            soff_sync_ff <= 1'b0;
            pdn_meta_ff  <= 1'b1;
            pdn_sync_ff  <= 1'b1;
        end
        else
        begin
            soff_meta_ff <= spread_off_n_input;
            soff_sync_ff <= soff_meta_ff;
            pdn_meta_ff  <= power_down_n;
            pdn_sync_ff  <= pdn_meta_ff;
        end
    end

    // Synchronise the reference enable
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            reference_output_enable_n_meta_ff <= 1'b1;
            reference_output_enable_n_sync_ff <= 1'b1;
        end
        else
        begin
            reference_output_enable_n_meta_ff <= reference_output_enable_n;
            reference_output_enable_n_sync_ff <= reference_output_enable_n_meta_ff;
        end
    end

    // Synchronise the profile reset pin and keep its last level
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            prst_meta_ff <= 1'b0;
            prst_sync_ff <= 1'b0;
            prst_prev_ff <= 1'b0;
        end
        else
        begin
            prst_meta_ff <= profile_reset_pin;
            prst_sync_ff <= prst_meta_ff;
            prst_prev_ff <= prst_sync_ff;
        end
    end

    // Rising edge of the profile reset pin
    assign restart    = prst_sync_ff & ~prst_prev_ff;              // [R7] [R14]
    assign spread_off = soff_sync_ff;                              // [R9]
    assign clk_run    = locked_ff & pdn_sync_ff & ~reserved;       // [R10]

    // Profile generator
    sscc_profile_gen
    #(
        .STEP_CYCLES (STEP_CYCLES)
    )
    u_profile
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .restart  (restart),
        .hold     (spread_off),                                    // [R9] [R18]
        .phase_ff (),
        .wave_ff  (wave)
    );

    // Instantaneous frequency word
    always @*
    begin
        {ratio, spread, down_mode, reserved} = sel_decode(sel_hold_ff);
        dev_prod = ratio * spread;
        dev_full = $signed({1'b0, dev_prod[31:16]});
        if (spread_off)
            wave_eff = 11'sh000;                                   // [R9]
        else if (down_mode)
            wave_eff = ($signed({wave[9], wave}) - $signed({1'b0, `SSCC_WAVE_FULL})) >>> 1; // [R6]
        else
            wave_eff = $signed({wave[9], wave});                   // [R5]
        dev_scaled = dev_full * wave_eff;
        dev_shift  = dev_scaled[26:8];
        freq_sum   = $signed({3'h0, ratio}) + dev_shift;           // [R1]
        if (reserved)
            nxt_freq_word = 16'h0000;
        else
            nxt_freq_word = freq_sum[15:0];
    end

    // Numerically controlled output oscillator
    always @*
    begin
        if (clk_run)
            nxt_nco_acc = nco_acc_ff + freq_word_ff[NCO_W-1:0];    // [R1]
        else
            nxt_nco_acc = {NCO_W{1'b0}};                           // [R10]
    end

    // Lock timer after power-down release
    always @*
    begin
        nxt_lock_cnt = lock_cnt_ff;
        nxt_locked   = locked_ff;
        if (!pdn_sync_ff)
        begin
            nxt_lock_cnt = {LOCK_W{1'b0}};                         // [R10]
            nxt_locked   = 1'b0;
        end
        else if (!locked_ff)
        begin
            if (lock_cnt_ff == LOCK_CYCLES - 1)
                nxt_locked = 1'b1;                                 // [R13]
            else
                nxt_lock_cnt = lock_cnt_ff + 1'b1;
        end
    end

    // State registers
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            lock_cnt_ff  <= {LOCK_W{1'b0}};
            locked_ff    <= 1'b0;
            nco_acc_ff   <= {NCO_W{1'b0}};
            freq_word_ff <= 16'h0000;
        end
        else
        begin
            lock_cnt_ff  <= nxt_lock_cnt;
            locked_ff    <= nxt_locked;
            nco_acc_ff   <= nxt_nco_acc;
            freq_word_ff <= nxt_freq_word;                         // [R2] [R3]
        end
    end

    // Output flops
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            modulated_clock_out    <= 1'b0;
            buffered_reference_out <= 1'b0;
            buffered_reference_oe  <= 1'b0;
            freq_word_out          <= 16'h0000;
            pll_locked             <= 1'b0;
            select_reserved        <= 1'b0;
        end
        else
        begin
            modulated_clock_out    <= clk_run & nco_acc_ff[NCO_W-1];        // [R11] [R12]
            buffered_reference_out <= pdn_sync_ff & ~reference_output_enable_n_sync_ff;         // [R8] [R15]
            buffered_reference_oe  <= ~(pdn_sync_ff & reference_output_enable_n_sync_ff);       // [R17] [R12]
            freq_word_out          <= freq_word_ff;
            pll_locked             <= locked_ff;
            select_reserved        <= reserved;                             // [R16]
        end
    end

endmodule // sscc_clock_control

// ===== sim/sscc_pin_model.sv
// Pin driver standing for the system logic
// Assumes pins change on the falling edge of sys_clk
`timescale 1ns/1ns
module sscc_pin_model
(
    // Clock
    input  wire       sys_clk,
    // Control pins
    output reg  [2:0] spread_select,
    output reg        spread_off_n_input,
    output reg        power_down_n,
    output reg        reference_output_enable_n,
    output reg        profile_reset_pin
);
    initial
    begin
        spread_select = 3'h0;
        spread_off_n_input = 1'b0;
        power_down_n = 1'b1;
        reference_output_enable_n = 1'b0;
        profile_reset_pin = 1'b0;
    end
    // Set the level pins
    task drive(input [2:0] sel, input off, input pd_n, input en_n);
    begin
        @(negedge sys_clk);
        spread_select = sel;
        spread_off_n_input = off;
        power_down_n = pd_n;
        reference_output_enable_n = en_n;
    end
    endtask
    // Low, then high, restarts the profile
    task restart;
    begin
        @(negedge sys_clk);
        profile_reset_pin = 1'b0;
        repeat (3) @(negedge sys_clk);
        profile_reset_pin = 1'b1;
    end
    endtask
endmodule // sscc_pin_model

// ===== sim/sscc_clock_control_monitor.sv
// Checker on the ports of the clock control block
// Assumes one clock, synchronous active-high reset
`timescale 1ns/1ns
module sscc_monitor
(
    // Clock and reset
    input wire        sys_clk,
    input wire        reset,
    // Control pins
    input wire [2:0]  spread_select,
    input wire        spread_off_n_input,
    input wire        power_down_n,
    input wire        reference_output_enable_n,
    input wire        profile_reset_pin,
    // Outputs
    input wire        modulated_clock_out,
    input wire        buffered_reference_out,
    input wire        buffered_reference_oe,
    input wire [15:0] freq_word_out,
    input wire        pll_locked,
    input wire        select_reserved
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire run0 = power_down_n && !spread_off_n_input && spread_select == 3'h0;
    wire rsv  = spread_select == 3'h5 || spread_select == 3'h7;

    a_pd_stops_out: assert property (
        (!power_down_n)[*5] |-> !modulated_clock_out && !buffered_reference_out && !pll_locked)
        else $error("outputs still active in power down");
    a_ref_on: assert property (
        (power_down_n && !reference_output_enable_n)[*5] |->
        buffered_reference_out && buffered_reference_oe)
        else $error("reference output not enabled");
    a_ref_off: assert property (
        reference_output_enable_n[*5] |-> !buffered_reference_out)
        else $error("reference output not disabled");
    a_ref_hiz: assert property (
        (power_down_n && reference_output_enable_n)[*5] |-> !buffered_reference_oe)
        else $error("reference output not released");
    a_reserved_code: assert property (
        rsv[*7] |-> select_reserved && freq_word_out == 16'h0000 && !modulated_clock_out)
        else $error("reserved code not refused");
    a_spread_off_flat: assert property (
        (spread_off_n_input && power_down_n && spread_select == 3'h0)[*7] |->
        freq_word_out == 16'h2000)
        else $error("modulation not stopped");
    a_center_band: assert property (
        run0[*7] |-> freq_word_out >= 16'h1F34 && freq_word_out <= 16'h20CC)
        else $error("center spread out of band");
    a_down_limit: assert property (
        (power_down_n && spread_select == 3'h6)[*7] |->
        freq_word_out <= 16'h6FBF && freq_word_out >= 16'h6D83)
        else $error("down spread out of band");
    a_restart_start: assert property (
        $rose(profile_reset_pin) && run0 |-> ##[4:7] freq_word_out == 16'h2000)
        else $error("profile not restarted");

    c_lock: cover property ($rose(pll_locked));
    c_reserved: cover property (select_reserved);
    c_restart: cover property ($rose(profile_reset_pin) && run0);
endmodule // sscc_monitor

bind sscc_clock_control sscc_monitor MON (.sys_clk(sys_clk), .reset(reset),
    .spread_select(spread_select), .spread_off_n_input(spread_off_n_input),
    .power_down_n(power_down_n), .reference_output_enable_n(reference_output_enable_n),
    .profile_reset_pin(profile_reset_pin), .modulated_clock_out(modulated_clock_out),
    .buffered_reference_out(buffered_reference_out),
    .buffered_reference_oe(buffered_reference_oe), .freq_word_out(freq_word_out),
    .pll_locked(pll_locked), .select_reserved(select_reserved));

// ===== sim/tb_sscc_clock_control.sv
// Testbench of the spread spectrum clock control block
// Assumes 20 MHz reference, lock count shortened to 20 cycles
`timescale 1ns/1ns
module tb_sscc_clock_control;
    localparam LOCK = 20;
    reg         sys_clk;
    reg         reset;
    wire [2:0]  sel;
    wire        off, pd_n, en_n, rst_pin, clk_o, ref_o, ref_oe, locked, rsv;
    wire [15:0] word;
    integer     n_errors, n_tests, i, cnt;
    reg  [15:0] lo, hi, w0;
    reg         pv;
    reg  [15:0] ratio [0:7];

    sscc_pin_model PIN (.sys_clk(sys_clk), .spread_select(sel), .spread_off_n_input(off),
        .power_down_n(pd_n), .reference_output_enable_n(en_n), .profile_reset_pin(rst_pin));
    sscc_clock_control #(.LOCK_CYCLES(LOCK)) DUT (.sys_clk(sys_clk), .reset(reset),
        .spread_select(sel), .spread_off_n_input(off), .power_down_n(pd_n),
        .reference_output_enable_n(en_n), .profile_reset_pin(rst_pin),
        .modulated_clock_out(clk_o), .buffered_reference_out(ref_o),
        .buffered_reference_oe(ref_oe), .freq_word_out(word), .pll_locked(locked),
        .select_reserved(rsv));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task check(input [31:0] seen, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    end
    endtask

    task stop_test;
    begin
        if (n_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    task cycles(input integer n);
        repeat (n) @(negedge sys_clk);
    endtask

    task wait_lock;
    begin
        cnt = 0;
        while (locked !== 1'b1 && cnt < 300)
        begin
            @(negedge sys_clk);
            cnt = cnt + 1;
        end
        check(cnt < 300, 1);
        if (cnt >= 300)
            stop_test;
    end
    endtask

    // Extremes of the ratio word
    task sweep(input integer n);
    begin
        lo = 16'hFFFF;
        hi = 16'h0000;
        repeat (n)
        begin
            @(negedge sys_clk);
            if (word < lo) lo = word;
            if (word > hi) hi = word;
        end
    end
    endtask

    initial
    begin
        n_errors = 0;
        n_tests = 0;
        reset = 1'b1;
        ratio[0] = 16'h2000; ratio[1] = 16'h2000; ratio[2] = 16'h2000; ratio[3] = 16'h1000;
        ratio[4] = 16'h4A7E; ratio[5] = 16'h0000; ratio[6] = 16'h6FBF; ratio[7] = 16'h0000;
        cycles(4);
        reset = 1'b0;
        wait_lock;
        check(cnt >= LOCK && cnt <= LOCK + 6, 1);
        for (i = 0; i < 8; i = i + 1)
        begin
            PIN.drive(i[2:0], 1'b1, 1'b1, 1'b0);
            cycles(8);
            check(word, ratio[i]);
            check(rsv, i == 5 || i == 7);
            w0 = word;
            cycles(40);
            check(word, w0);
            if (i == 5 || i == 7) check(clk_o, 0);
        end
        PIN.drive(3'h3, 1'b1, 1'b1, 1'b0);
        wait_lock;
        cycles(8);
        cnt = 0;
        pv = clk_o;
        repeat (1024)
        begin
            @(negedge sys_clk);
            if (clk_o !== pv) cnt = cnt + 1;
            pv = clk_o;
        end
        check(cnt >= 127 && cnt <= 129, 1);
        PIN.drive(3'h0, 1'b0, 1'b1, 1'b0);
        wait_lock;
        PIN.restart;
        cycles(100);
        w0 = word;
        sweep(512);
        check(word, w0);
        check(hi, 16'h20CC);
        check(lo, 16'h1F34);
        sweep(333);
        PIN.restart;
        cycles(100);
        check(word, w0);
        PIN.drive(3'h6, 1'b0, 1'b1, 1'b0);
        cycles(8);
        sweep(520);
        check(hi <= 16'h6FBF, 1);
        check(lo, 16'h6D83);
        PIN.drive(3'h6, 1'b0, 1'b1, 1'b1);
        cycles(4);
        check({ref_oe, ref_o}, 2'b00);
        PIN.drive(3'h6, 1'b0, 1'b1, 1'b0);
        cycles(4);
        check({ref_oe, ref_o}, 2'b11);
        PIN.drive(3'h6, 1'b0, 1'b0, 1'b1);
        cycles(4);
        check({ref_oe, ref_o, clk_o, locked}, 4'b1000);
        cycles(4);
        PIN.drive(3'h6, 1'b0, 1'b1, 1'b0);
        wait_lock;
        check(cnt >= LOCK && cnt <= LOCK + 6, 1);
        check({ref_oe, ref_o}, 2'b11);
        stop_test;
    end
endmodule // tb_sscc_clock_control
